//--- shared/mpc_pkg.sv
// Constants for the multipurpose pin configuration block.
// Assumes byte-wide registers on an 8-bit register address space.
package mpc_pkg;
	localparam int unsigned NUM_PINS = 4;
	localparam int unsigned SYNC_STAGES = 3;
	// Register offsets, pin two through pin five
	localparam logic [7:0] OFS_PIN2 = 8'h8c;
	localparam logic [7:0] OFS_PIN3 = 8'h8d;
	localparam logic [7:0] OFS_PIN4 = 8'h8e;
	localparam logic [7:0] OFS_PIN5 = 8'h8f;
	// Reset values
	localparam logic [7:0] RST_PIN2 = 8'h20;
	localparam logic [7:0] RST_PIN3 = 8'h00;
	localparam logic [7:0] RST_PIN4 = 8'h00;
	localparam logic [7:0] RST_PIN5 = 8'h01;
	// Field positions
	localparam int unsigned INVERT_BIT = 5;
	localparam int unsigned TYPE_HI = 4;
	localparam int unsigned TYPE_LO = 3;
	localparam int unsigned FUNC_HI = 2;
	localparam int unsigned FUNC_LO = 0;
	localparam logic [7:0] WRITE_MASK = 8'h3f;
	// Output type codes
	localparam logic [1:0] TYPE_HIGHZ = 2'h0;
	localparam logic [1:0] TYPE_OPEN_DRAIN = 2'h1;
	// Function codes
	typedef enum logic [2:0] {
		FUNC_DISABLED = 3'h0,
		FUNC_COLD_RESET_IN = 3'h1,
		FUNC_VR_POWER_GOOD_IN = 3'h2,
		FUNC_REG_INPUT = 3'h3,
		FUNC_POWER_GOOD_OUT = 3'h4,
		FUNC_RESET_OUT = 3'h5,
		FUNC_VR_ENABLE_OUT = 3'h6,
		FUNC_REG_OUTPUT = 3'h7
	} mpc_func_e;
endpackage : mpc_pkg

//--- rtl/mpc_pin_cell.sv
// One multipurpose pin: input synchroniser, polarity and open-drain driver.
// Assumes the config byte comes from registers on the same clock.
`timescale 1ns/1ps
module mpc_pin_cell #(
	parameter bit WDT_ON_CODE1 = 1'b0
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Configuration
	input wire logic [7:0] cfg_i,
	// Role sources for output functions
	input wire logic power_good_i,
	input wire logic reset_out_i,
	input wire logic vr_enable_i,
	input wire logic reg_drive_i,
	input wire logic watchdog_i,
	// Pin
	input wire logic pin_i,
	output logic pin_o,
	output logic pin_oe_o,
	// Decoded state
	output logic asserted_o,
	output logic [2:0] func_o,
	output logic delay_en_o
);
	typedef struct packed {
		logic [mpc_pkg::SYNC_STAGES-1:0] sync;
		logic filt;
	} mpc_cell_s;

	mpc_cell_s st_q;
	mpc_cell_s st_d;
	logic invert;
	logic [1:0] otype;
	logic is_out;
	logic want;
	logic level;

	always_comb begin
		st_d = st_q;
		st_d.sync = {st_q.sync[1:0], pin_i};
		// Accept a change only when stages two and three agree
		if (st_q.sync[1] == st_q.sync[2]) begin
			st_d.filt = st_q.sync[2];
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign invert = cfg_i[mpc_pkg::INVERT_BIT];
	assign otype = cfg_i[mpc_pkg::TYPE_HI:mpc_pkg::TYPE_LO];
	assign func_o = cfg_i[mpc_pkg::FUNC_HI:mpc_pkg::FUNC_LO];
	assign delay_en_o = (func_o != mpc_pkg::FUNC_DISABLED);

	always_comb begin
		is_out = 1'b1;
		want = 1'b0;
		unique case (func_o)
			mpc_pkg::FUNC_POWER_GOOD_OUT: want = power_good_i;
			mpc_pkg::FUNC_RESET_OUT: want = reset_out_i;
			mpc_pkg::FUNC_VR_ENABLE_OUT: want = vr_enable_i;
			mpc_pkg::FUNC_REG_OUTPUT: want = reg_drive_i;
			mpc_pkg::FUNC_COLD_RESET_IN: begin
				is_out = WDT_ON_CODE1;
				want = watchdog_i;
			end
			default: is_out = 1'b0;
		endcase
	end

	assign level = invert ? want : ~want;
	assign pin_o = 1'b0;
	// Open drain only pulls low; other type codes leave the pin floating
	assign pin_oe_o = is_out && (otype == mpc_pkg::TYPE_OPEN_DRAIN) && !level;
	assign asserted_o = !is_out && delay_en_o && (invert ? st_q.filt : ~st_q.filt);

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	highz_no_drive_a: assert property (otype == mpc_pkg::TYPE_HIGHZ |-> !pin_oe_o)
		else $error("pin driven while type is high impedance");
	od_pull_low_a: assert property (is_out && otype == mpc_pkg::TYPE_OPEN_DRAIN
		|-> pin_oe_o == (invert != want))
		else $error("open drain drive does not follow role and polarity");
	disabled_quiet_a: assert property (func_o == mpc_pkg::FUNC_DISABLED
		|-> !pin_oe_o && !asserted_o && !delay_en_o)
		else $error("disabled pin still active");
	highz_delays_a: assert property (otype == mpc_pkg::TYPE_HIGHZ
		&& func_o != mpc_pkg::FUNC_DISABLED |-> delay_en_o)
		else $error("delays dropped on high impedance pin");
	input_polarity_a: assert property (func_o == mpc_pkg::FUNC_REG_INPUT && $stable(cfg_i)
		&& $stable(pin_i) [*4] |-> asserted_o == (pin_i == invert))
		else $error("input polarity wrong after settling");
	role_select_a: assert property (func_o == mpc_pkg::FUNC_POWER_GOOD_OUT
		&& otype == mpc_pkg::TYPE_OPEN_DRAIN |-> pin_oe_o == (power_good_i != invert))
		else $error("power good role not routed");
	od_drive_c: cover property (pin_oe_o ##1 !pin_oe_o);
	input_seen_c: cover property (!asserted_o ##1 asserted_o);
endmodule : mpc_pin_cell

//--- rtl/mpc_multipurpose_pin_config.sv
// Configuration registers and pin cells for multipurpose pins two to five.
// Assumes the serial-bus slave issues one-cycle read and write strobes and
// the non-volatile loader presents all four bytes with a one-cycle load strobe.
// Polarity, drive and input filtering live in one cell per pin.
//
// Behaviour
// - Bit 5 selects polarity: 0 active low, 1 active high.
// - Type field 00 turns the pin driver off, pin floats.
// - With type 00, power delays still apply when function is nonzero.
// - Type field 01 makes an open-drain output that only pulls low.
// - Function 000 disables the pin and its power delays.
// - Function field picks one of eight input, output or disabled roles.
`timescale 1ns/1ps
module mpc_multipurpose_pin_config (
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Register access
	input wire logic wr_en_i,
	input wire logic rd_en_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o,
	output logic rvalid_o,
	output logic hit_o,
	// Non-volatile load, byte 0 is pin two
	input wire logic nvm_load_i,
	input wire logic [31:0] nvm_data_i,
	// Role sources
	input wire logic power_good_i,
	input wire logic reset_out_i,
	input wire logic vr_enable_i,
	input wire logic watchdog_reset_out_n_i,
	input wire logic [3:0] reg_drive_i,
	// Pins, index 0 is pin two
	input wire logic [3:0] multipurpose_pin_i,
	output logic [3:0] multipurpose_pin_o,
	output logic [3:0] multipurpose_pin_oe_o,
	// Decoded state toward the rest of the device
	output logic [3:0] pin_asserted_o,
	output logic [3:0] delay_en_o,
	output logic cold_reset_in_o,
	output logic vr_power_good_o,
	output logic [3:0] reg_input_o
);
	typedef struct packed {
		logic [3:0][7:0] cfg;
		logic [7:0] rdata;
		logic rvalid;
	} mpc_regs_s;

	mpc_regs_s st_q;
	mpc_regs_s st_d;
	logic [3:0] sel;
	logic [3:0][2:0] func;
	logic [3:0] cold;
	logic [3:0] power_good;

	assign sel[0] = (addr_i == mpc_pkg::OFS_PIN2);
	assign sel[1] = (addr_i == mpc_pkg::OFS_PIN3);
	assign sel[2] = (addr_i == mpc_pkg::OFS_PIN4);
	assign sel[3] = (addr_i == mpc_pkg::OFS_PIN5);
	assign hit_o = |sel;

	always_comb begin
		st_d = st_q;
		st_d.rvalid = rd_en_i;
		if (rd_en_i) begin
			st_d.rdata = 8'h00;
			for (int i = 0; i < 4; i++) begin
				if (sel[i]) begin
					st_d.rdata = st_q.cfg[i] & mpc_pkg::WRITE_MASK;
				end
			end
		end
		// Loader wins over a host write landing in the same cycle
		if (nvm_load_i) begin
			for (int i = 0; i < 4; i++) begin
				st_d.cfg[i] = nvm_data_i[i*8 +: 8] & mpc_pkg::WRITE_MASK;
			end
		end else if (wr_en_i) begin
			for (int i = 0; i < 4; i++) begin
				if (sel[i]) begin
					st_d.cfg[i] = wdata_i & mpc_pkg::WRITE_MASK;
				end
			end
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_q.cfg[0] <= mpc_pkg::RST_PIN2;
			st_q.cfg[1] <= mpc_pkg::RST_PIN3;
			st_q.cfg[2] <= mpc_pkg::RST_PIN4;
			st_q.cfg[3] <= mpc_pkg::RST_PIN5;
			st_q.rdata <= 8'h00;
			st_q.rvalid <= 1'b0;
		end else begin
			st_q <= st_d;
		end
	end

	assign rdata_o = st_q.rdata;
	assign rvalid_o = st_q.rvalid;

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_pin
			// Pin four carries the watchdog reset output on function code one
			mpc_pin_cell #(
				.WDT_ON_CODE1(g == 2)
			) u_cell (
				.clk_i(clk_i),
				.resetn_i(resetn_i),
				.cfg_i(st_q.cfg[g]),
				.power_good_i(power_good_i),
				.reset_out_i(reset_out_i),
				.vr_enable_i(vr_enable_i),
				.reg_drive_i(reg_drive_i[g]),
				.watchdog_i(!watchdog_reset_out_n_i),
				.pin_i(multipurpose_pin_i[g]),
				.pin_o(multipurpose_pin_o[g]),
				.pin_oe_o(multipurpose_pin_oe_o[g]),
				.asserted_o(pin_asserted_o[g]),
				.func_o(func[g]),
				.delay_en_o(delay_en_o[g])
			);
			assign cold[g] = pin_asserted_o[g] && func[g] == mpc_pkg::FUNC_COLD_RESET_IN;
			assign power_good[g] = pin_asserted_o[g] && func[g] == mpc_pkg::FUNC_VR_POWER_GOOD_IN;
			assign reg_input_o[g] = pin_asserted_o[g] && func[g] == mpc_pkg::FUNC_REG_INPUT;
		end
	endgenerate

	assign cold_reset_in_o = |cold;
	assign vr_power_good_o = |power_good;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	unused_bits_zero_a: assert property (rvalid_o |-> rdata_o[7:6] == 2'h0)
		else $error("unused bits read nonzero");
	write_stored_a: assert property (wr_en_i && !nvm_load_i && sel[3]
		##1 rd_en_i && sel[3] && !wr_en_i && !nvm_load_i
		|=> rdata_o == ($past(wdata_i, 2) & mpc_pkg::WRITE_MASK))
		else $error("written value not read back masked");
	unmapped_zero_a: assert property (rd_en_i && !hit_o |=> rvalid_o && rdata_o == 8'h00)
		else $error("unmapped read not zero");

	// Read answer comes exactly one cycle after the strobe
	rvalid_pulse_a: assert property (rd_en_i |=> rvalid_o)
		else $error("read answer missing");
	rvalid_idle_a: assert property (!rd_en_i |=> !rvalid_o)
		else $error("read answer without a read");

	// Load takes all four bytes, masked, and beats a host write
	load_masked_a: assert property (nvm_load_i
		|=> st_q.cfg == ($past(nvm_data_i) & {4{mpc_pkg::WRITE_MASK}}))
		else $error("load not stored masked");
	unmapped_write_a: assert property (wr_en_i && !hit_o && !nvm_load_i
		|=> $stable(st_q.cfg))
		else $error("unmapped write changed a register");

	// Per-pin store: a write lands masked, anything but a write or a load leaves the byte alone
	pin2_write_a: assert property (wr_en_i && sel[0] && !nvm_load_i
		|=> st_q.cfg[0] == ($past(wdata_i) & mpc_pkg::WRITE_MASK))
		else $error("pin two write not stored");
	pin3_write_a: assert property (wr_en_i && sel[1] && !nvm_load_i
		|=> st_q.cfg[1] == ($past(wdata_i) & mpc_pkg::WRITE_MASK))
		else $error("pin three write not stored");
	pin4_write_a: assert property (wr_en_i && sel[2] && !nvm_load_i
		|=> st_q.cfg[2] == ($past(wdata_i) & mpc_pkg::WRITE_MASK))
		else $error("pin four write not stored");
	pin5_write_a: assert property (wr_en_i && sel[3] && !nvm_load_i
		|=> st_q.cfg[3] == ($past(wdata_i) & mpc_pkg::WRITE_MASK))
		else $error("pin five write not stored");
	pin2_hold_a: assert property (!nvm_load_i && !(wr_en_i && sel[0])
		|=> $stable(st_q.cfg[0]))
		else $error("pin two changed without a write");
	pin3_hold_a: assert property (!nvm_load_i && !(wr_en_i && sel[1])
		|=> $stable(st_q.cfg[1]))
		else $error("pin three changed without a write");
	pin4_hold_a: assert property (!nvm_load_i && !(wr_en_i && sel[2])
		|=> $stable(st_q.cfg[2]))
		else $error("pin four changed without a write");
	pin5_hold_a: assert property (!nvm_load_i && !(wr_en_i && sel[3])
		|=> $stable(st_q.cfg[3]))
		else $error("pin five changed without a write");

	// Per-pin read: the byte as it stood when the strobe was taken
	pin2_read_a: assert property (rd_en_i && sel[0]
		|=> rdata_o == $past(st_q.cfg[0]))
		else $error("pin two read wrong");
	pin3_read_a: assert property (rd_en_i && sel[1]
		|=> rdata_o == $past(st_q.cfg[1]))
		else $error("pin three read wrong");
	pin4_read_a: assert property (rd_en_i && sel[2]
		|=> rdata_o == $past(st_q.cfg[2]))
		else $error("pin four read wrong");
	pin5_read_a: assert property (rd_en_i && sel[3]
		|=> rdata_o == $past(st_q.cfg[3]))
		else $error("pin five read wrong");

	// Pin four carries the watchdog output, never the cold reset input
	pin4_no_cold_a: assert property (func[2] == mpc_pkg::FUNC_COLD_RESET_IN
		|-> !pin_asserted_o[2] && !cold[2])
		else $error("pin four reported as cold reset input");
	// Decoded inputs only come from enabled pins in an input role
	asserted_enabled_a: assert property ((pin_asserted_o & ~delay_en_o) == 4'h0)
		else $error("disabled pin reports asserted");
	cold_needs_pin_a: assert property (cold_reset_in_o |-> |(pin_asserted_o & delay_en_o))
		else $error("cold reset input without an asserted pin");
	vr_pg_needs_pin_a: assert property (vr_power_good_o |-> |(pin_asserted_o & delay_en_o))
		else $error("power good input without an asserted pin");
	reg_input_role_a: assert property ((reg_input_o & ~pin_asserted_o) == 4'h0)
		else $error("register input bit without asserted pin");

	// Main scenarios
	wr_c: cover property (wr_en_i && sel[0] ##1 rd_en_i && sel[0]);
	unmapped_rd_c: cover property (rd_en_i && !hit_o);
	load_c: cover property (nvm_load_i ##1 |delay_en_o);
endmodule : mpc_multipurpose_pin_config

//--- bench/mpc_host_model.sv
// Host-side model issuing single-byte register writes and reads.
// Assumes the block takes strobes on the rising clock edge.
`timescale 1ns/1ps
module mpc_host_model (
	// Clock
	input wire logic clk_i,
	// Register access
	output logic wr_en_o,
	output logic rd_en_o,
	output logic [7:0] addr_o,
	output logic [7:0] wdata_o,
	input wire logic [7:0] rdata_i,
	input wire logic rvalid_i
);
	initial begin
		wr_en_o = 1'b0;
		rd_en_o = 1'b0;
		addr_o = 8'h00;
		wdata_o = 8'h5a;
	end
	task automatic write(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_i);
		wr_en_o = 1'b1;
		addr_o = a;
		wdata_o = d;
		@(negedge clk_i);
		wr_en_o = 1'b0;
		// Released data lines must not keep the last byte
		wdata_o = ~d;
	endtask : write
	// Write, then read the same byte on the very next cycle
	task automatic write_read(input logic [7:0] a, input logic [7:0] wd, output logic [7:0] d,
		output logic v);
		@(negedge clk_i);
		wr_en_o = 1'b1;
		addr_o = a;
		wdata_o = wd;
		@(negedge clk_i);
		wr_en_o = 1'b0;
		rd_en_o = 1'b1;
		wdata_o = ~wd;
		@(negedge clk_i);
		rd_en_o = 1'b0;
		d = rdata_i;
		v = rvalid_i;
	endtask : write_read
	task automatic read(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(negedge clk_i);
		rd_en_o = 1'b1;
		addr_o = a;
		@(negedge clk_i);
		rd_en_o = 1'b0;
		d = rdata_i;
		v = rvalid_i;
	endtask : read
endmodule : mpc_host_model

//--- bench/mpc_multipurpose_pin_config_tb.sv
// Random and corner tests of the pin configuration block.
// Assumes a host model drives the register strobes.
`timescale 1ns/1ps
module mpc_multipurpose_pin_config_tb;
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic wr_en, rd_en, rvalid, hit, cri, vpg, v, ec, ev;
	logic nvm_load = 1'b0, pg = 1'b0, ro = 1'b0, vre = 1'b0, wdn = 1'b1;
	logic [7:0] addr, wdata, rdata, d, b;
	logic [31:0] nvm_data = 32'h0;
	logic [3:0] drv = 4'h0, pin_in = 4'h0, pin_o, oe, asr, dly, rin;
	logic [7:0] cfg [4] = '{8'h20, 8'h00, 8'h00, 8'h01};
	int fail_count = 0;
	int checks_done = 0;
	always #5 clk_i = ~clk_i;
	mpc_host_model host_u (.clk_i(clk_i), .wr_en_o(wr_en), .rd_en_o(rd_en), .addr_o(addr),
		.wdata_o(wdata), .rdata_i(rdata), .rvalid_i(rvalid));
	mpc_multipurpose_pin_config dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .wr_en_i(wr_en),
		.rd_en_i(rd_en), .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata), .rvalid_o(rvalid),
		.hit_o(hit), .nvm_load_i(nvm_load), .nvm_data_i(nvm_data), .power_good_i(pg),
		.reset_out_i(ro), .vr_enable_i(vre), .watchdog_reset_out_n_i(wdn), .reg_drive_i(drv),
		.multipurpose_pin_i(pin_in), .multipurpose_pin_o(pin_o), .multipurpose_pin_oe_o(oe),
		.pin_asserted_o(asr), .delay_en_o(dly), .cold_reset_in_o(cri),
		.vr_power_good_o(vpg), .reg_input_o(rin));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk
	function automatic logic exp_oe(input int p, input logic [7:0] c);
		logic r;
		r = c[2:0] == 3'h4 ? pg : c[2:0] == 3'h5 ? ro : c[2:0] == 3'h6 ? vre :
			c[2:0] == 3'h7 ? drv[p] : !wdn;
		return (c[2:0] > 3'h3 || (c[2:0] == 3'h1 && p == 2)) &&
			c[4:3] == mpc_pkg::TYPE_OPEN_DRAIN && (c[5] ? r : !r) == 1'b0;
	endfunction : exp_oe
	function automatic logic exp_in(input int p, input logic [7:0] c);
		return (c[2:0] == 3'h2 || c[2:0] == 3'h3 || (c[2:0] == 3'h1 && p != 2)) &&
			(c[5] ? pin_in[p] : !pin_in[p]);
	endfunction : exp_in
	task automatic check_all;
		ec = 1'b0;
		ev = 1'b0;
		for (int p = 0; p < 4; p++) begin
			chk(oe[p], exp_oe(p, cfg[p]), "drive enable");
			chk(pin_o[p], 1'b0, "pin level");
			chk(dly[p], cfg[p][2:0] != 3'h0, "delay enable");
			chk(asr[p], exp_in(p, cfg[p]), "asserted");
			chk(rin[p], exp_in(p, cfg[p]) && cfg[p][2:0] == 3'h3, "reg input");
			ec |= exp_in(p, cfg[p]) && cfg[p][2:0] == 3'h1;
			ev |= exp_in(p, cfg[p]) && cfg[p][2:0] == 3'h2;
			host_u.read(8'h8c + 8'(p), d, v);
			chk(d, cfg[p], "read back");
			chk({v, hit}, 2'h3, "read answer");
		end
		chk(cri, ec, "cold reset in");
		chk(vpg, ev, "vr power good");
	endtask : check_all
	task close_out;
		$display("checks %0d failures %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : close_out
	initial begin
		#100us;
		fail_count++;
		close_out();
	end
	initial begin
		void'($urandom(32'ha878));
		repeat (5) @(negedge clk_i);
		resetn_i = 1'b1;
		repeat (6) @(negedge clk_i);
		check_all();
		host_u.read(8'h90, d, v);
		chk(d, 8'h00, "unmapped read");
		chk({v, hit}, 2'h2, "unmapped answer");
		host_u.write(8'h91, 8'hff);
		host_u.write(8'h8f, 8'hff);
		cfg[3] = 8'h3f;
		check_all();
		for (int i = 0; i < 64; i++) begin
			b = 8'($urandom);
			b[2:0] = i[4:2];
			if (i == 40) begin
				@(negedge clk_i);
				nvm_data = $urandom;
				nvm_load = 1'b1;
				@(negedge clk_i);
				nvm_load = 1'b0;
				for (int p = 0; p < 4; p++)
					cfg[p] = nvm_data[8*p +: 8] & 8'h3f;
			end else begin
				host_u.write_read(8'h8c + 8'(i[1:0]), b, d, v);
				cfg[i[1:0]] = b & 8'h3f;
				chk(d, b & 8'h3f, "write then read");
				chk(v, 1'b1, "write then read answer");
			end
			@(negedge clk_i);
			{pg, ro, vre, wdn, drv, pin_in} = 12'($urandom);
			repeat (6) @(negedge clk_i);
			check_all();
		end
		close_out();
	end
endmodule : mpc_multipurpose_pin_config_tb
